/* core/rltc_ctrl.sv */
// Purpose: Test, link control and event bookkeeping registers of a channel.
// Assumes: Link word inputs come from receiver logic on clk_sys.
// Notes: Host port is word indexed; read data appears one cycle after rd.
`timescale 1ns/1ps
module rltc_ctrl import rltc_pkg::*; #(
  parameter int NS = NSRC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Host register port
  input wire rltc_host_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  // Real input link
  input wire rltc_link_word_t link_in,
  input wire logic link_in_valid,
  input wire logic link_down_n,
  // Link path toward the link FIFO
  output rltc_link_word_t il_word_ff,
  output logic il_valid_ff,
  output logic parity_err_ff,
  output logic link_reset_ff,
  output logic link_down_status_n,
  // Link FIFO and pipeline
  input wire logic lfifo_not_empty,
  output logic lfifo_pop,
  output logic pipe_freeze,
  // Buffer memory ports
  output logic bm_port1_link,
  output logic bm_port2_host,
  // Boundary scan and LEDs
  output logic jtag_tck,
  output logic jtag_tdi,
  output logic jtag_tms,
  input wire logic jtag_tdo,
  output logic [1:0] led,
  // Read-out stream
  input wire logic ro_valid,
  input wire logic ro_event_start,
  input wire logic ro_event_end,
  input wire logic [SLOT_W-1:0] ro_part,
  input wire logic ro_is_hdr,
  input wire logic ro_is_trl,
  input wire logic ro_src_empty,
  output logic ro_drop,
  output logic ro_truncate,
  output logic [NS-1:0] zs_flags_ff,
  output logic [NS-1:0] part_disable_ff,
  output logic readout_max_ff,
  // Front-end trailers
  input wire logic trl_valid,
  input wire logic [SLOT_W-1:0] trl_slot,
  input wire logic [EVID_W-1:0] trl_evid,
  output logic evid_late_ff,
  output logic evid_early_ff,
  output logic event_complete_ff,
  output logic [EVID_W-1:0] expid_ff
);
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] ctrl_prev_ff;
  logic [DATA_W-1:0] tdata_ff;
  logic [TSTAT_W-1:0] tstat_ff;
  logic [SZ_W-1:0] maxsz_ff;
  logic [NS-1:0] mask_ff;
  logic [NS-1:0] seen_ff;
  logic [2:0] ldn_sync_ff;
  logic [2:0] tdo_sync_ff;
  logic ldn_filt_ff;
  logic tdo_filt_ff;
  logic wr_ctrl;
  logic inj_rise;
  logic lrst_rise;
  logic test_mode;
  logic [CTRL_W-1:0] ctrl_rd;
  logic [DATA_W-1:0] nxt_rdata;
  logic [EVID_W-1:0] evid_diff;
  logic trl_match;
  logic all_seen;
  logic [NS-1:0] trl_onehot;

  assign wr_ctrl = reg_req.wr && reg_req.addr == A_CTRL;
  assign test_mode = ctrl_ff[B_TEST];

  // Control register; TDO and link-down positions are stored but replaced on read-back
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= reg_req.wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_prev_ff <= CTRL_RST;
    end else begin
      ctrl_prev_ff <= ctrl_ff;
    end
  end

  assign inj_rise = test_mode && ctrl_ff[B_INJ] && !ctrl_prev_ff[B_INJ];
  assign lrst_rise = ctrl_ff[B_LRST] && !ctrl_prev_ff[B_LRST];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tdata_ff <= '0;
      tstat_ff <= '0;
    end else begin
      if (reg_req.wr && reg_req.addr == A_TDATA) begin
        tdata_ff <= reg_req.wdata;
      end
      if (reg_req.wr && reg_req.addr == A_TSTAT) begin
        tstat_ff <= reg_req.wdata[TSTAT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      maxsz_ff <= MAXSZ_RST;
      mask_ff <= '0;
    end else begin
      // Zero is left to the host to avoid; the limit is used as written
      if (reg_req.wr && reg_req.addr == A_MAXSZ) begin
        maxsz_ff <= reg_req.wdata[SZ_W-1:0];
      end
      if (reg_req.wr && reg_req.addr == A_MASK) begin
        mask_ff <= reg_req.wdata[NS-1:0];
      end
    end
  end

  // Pin inputs: three stages, change accepted when stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ldn_sync_ff <= 3'h7;
      tdo_sync_ff <= 3'h0;
    end else begin
      ldn_sync_ff <= {ldn_sync_ff[1:0], link_down_n};
      tdo_sync_ff <= {tdo_sync_ff[1:0], jtag_tdo};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ldn_filt_ff <= 1'b1;
      tdo_filt_ff <= 1'b0;
    end else begin
      if (ldn_sync_ff[1] == ldn_sync_ff[2]) begin
        ldn_filt_ff <= ldn_sync_ff[2];
      end
      if (tdo_sync_ff[1] == tdo_sync_ff[2]) begin
        tdo_filt_ff <= tdo_sync_ff[2];
      end
    end
  end

  assign link_down_status_n = ldn_filt_ff;

  // Link word source: real link normally, host words in test mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      il_word_ff <= '0;
      il_valid_ff <= 1'b0;
    end else if (test_mode) begin
      il_valid_ff <= inj_rise;
      if (inj_rise) begin
        il_word_ff.data <= tdata_ff;
        il_word_ff.ctrl_n <= tstat_ff[TS_CTRL];
        il_word_ff.derr_n <= tstat_ff[TS_DERR];
      end
    end else begin
      il_valid_ff <= link_in_valid;
      if (link_in_valid) begin
        il_word_ff <= link_in;
      end
    end
  end

  // Parity bit sits in the data at PARITY_BIT; check covers all bits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      parity_err_ff <= 1'b0;
    end else begin
      parity_err_ff <= il_valid_ff &&
                       ((^il_word_ff.data) == ctrl_ff[B_PEVEN]);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      link_reset_ff <= 1'b0;
    end else begin
      link_reset_ff <= lrst_rise;
    end
  end

  assign pipe_freeze = ctrl_ff[B_FRZ];
  assign lfifo_pop = lfifo_not_empty && !ctrl_ff[B_FRZ];
  // Port 1 has no selector: link writes always own it
  assign bm_port1_link = 1'b1;
  assign bm_port2_host = ctrl_ff[B_BMHOST];
  assign jtag_tck = ctrl_ff[B_TCK];
  assign jtag_tdi = ctrl_ff[B_TDI];
  assign jtag_tms = ctrl_ff[B_TMS];
  assign led = ctrl_ff[B_LED1:B_LED0];

  // Zero suppression of empty sources
  assign ro_drop = ro_valid && ctrl_ff[B_ZS] && ro_src_empty &&
                   (ro_is_hdr || ro_is_trl);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      zs_flags_ff <= '0;
    end else begin
      // Set wins over the event-end clear
      if (ro_valid && ro_event_end) begin
        zs_flags_ff <= '0;
      end
      if (ro_drop && ro_part < SLOT_W'(NS)) begin
        zs_flags_ff[ro_part] <= 1'b1;
      end
    end
  end

  rltc_evsize #(.NS(NS), .SW(SZ_W)) u_evsize (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .max_size(maxsz_ff),
    .ro_valid(ro_valid),
    .ro_event_start(ro_event_start),
    .ro_part(ro_part),
    .ro_truncate(ro_truncate),
    .part_disable_ff(part_disable_ff),
    .readout_max_ff(readout_max_ff)
  );

  // Trailer bookkeeping against the expected id
  assign evid_diff = trl_evid - expid_ff;
  assign trl_match = trl_valid && evid_diff == '0;
  always_comb begin
    trl_onehot = '0;
    if (trl_match && trl_slot < SLOT_W'(NS)) begin
      trl_onehot[trl_slot] = 1'b1;
    end
  end
  assign all_seen = (|mask_ff) && (&(seen_ff | ~mask_ff));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seen_ff <= '0;
    end else if (all_seen || (reg_req.wr && reg_req.addr == A_EXPID)) begin
      seen_ff <= trl_onehot;
    end else begin
      seen_ff <= seen_ff | trl_onehot;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      expid_ff <= '0;
    end else if (reg_req.wr && reg_req.addr == A_EXPID) begin
      expid_ff <= reg_req.wdata[EVID_W-1:0];
    end else if (all_seen) begin
      expid_ff <= expid_ff + EVID_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_complete_ff <= 1'b0;
      evid_late_ff <= 1'b0;
      evid_early_ff <= 1'b0;
    end else begin
      event_complete_ff <= all_seen;
      // Past half of the id ring counts as late
      evid_late_ff <= trl_valid && evid_diff[EVID_W-1];
      evid_early_ff <= trl_valid && !evid_diff[EVID_W-1] && !trl_match;
    end
  end

  // Register read-back
  assign ctrl_rd = {ctrl_ff[CTRL_W-1:B_LDN+1], ldn_filt_ff, tdo_filt_ff,
                    ctrl_ff[B_TDO-1:0]};
  always_comb begin
    nxt_rdata = '0;
    unique case (reg_req.addr)
      A_CTRL: nxt_rdata[CTRL_W-1:0] = ctrl_rd;
      A_TDATA: nxt_rdata = tdata_ff;
      A_TSTAT: nxt_rdata[TSTAT_W-1:0] = tstat_ff;
      A_MAXSZ: nxt_rdata[SZ_W-1:0] = maxsz_ff;
      A_EXPID: nxt_rdata[EVID_W-1:0] = expid_ff;
      A_MASK: nxt_rdata[NS-1:0] = mask_ff;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= '0;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  // Checks
  sequence s_ctrl_wr(int b, logic v);
    reg_req.wr && reg_req.addr == A_CTRL && reg_req.wdata[b] == v;
  endsequence

  sequence s_inject;
    s_ctrl_wr(B_TEST, 1'b1) && reg_req.wdata[B_INJ] && !ctrl_ff[B_INJ]
      && ctrl_ff[B_TEST];
  endsequence

  inject_word_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_inject |=> ##1 il_valid_ff && il_word_ff.data == $past(tdata_ff))
    else $error("test word not injected");
  link_blocked_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    test_mode && !inj_rise |=> !il_valid_ff)
    else $error("real link passed in test mode");
  bm_owner_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl |=> bm_port2_host == $past(reg_req.wdata[B_BMHOST]))
    else $error("buffer port owner wrong");
  tdo_readonly_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_ctrl ##[1:4] (reg_req.rd && reg_req.addr == A_CTRL)
      |=> reg_rdata_ff[B_TDO] == $past(tdo_filt_ff))
    else $error("tdo bit took a write");
  lrst_once_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_ctrl_wr(B_LRST, 1'b1) && !ctrl_ff[B_LRST] |=> ##1 link_reset_ff
      ##1 !link_reset_ff)
    else $error("link reset not a single pulse");
  freeze_pop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pipe_freeze |-> !lfifo_pop)
    else $error("pop while frozen");
  parity_sense_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    il_valid_ff && !wr_ctrl |=> parity_err_ff ==
      ((^$past(il_word_ff.data)) == ctrl_ff[B_PEVEN]))
    else $error("parity sense wrong");
  expid_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    all_seen && !(reg_req.wr && reg_req.addr == A_EXPID)
      |=> expid_ff == $past(expid_ff) + EVID_W'(1) && event_complete_ff)
    else $error("expected id did not step");
  late_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    trl_valid && evid_diff[EVID_W-1] |=> evid_late_ff &&
      (!event_complete_ff || $past(all_seen)))
    else $error("late trailer not reported");
  zs_drop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ro_drop && !ro_event_end && ro_part < SLOT_W'(NS)
      |=> zs_flags_ff[$past(ro_part)])
    else $error("suppressed source not flagged");
endmodule : rltc_ctrl

/* core/rltc_evsize.sv */
// Purpose: Per-event word count against the maximum event size.
// Assumes: Read-out marks the first word of each event with ro_event_start.
// Notes: Truncation stands until the next event start.
`timescale 1ns/1ps
module rltc_evsize import rltc_pkg::*; #(
  parameter int NS = NSRC,
  parameter int SW = SZ_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Limit
  input wire logic [SW-1:0] max_size,
  // Read-out words
  input wire logic ro_valid,
  input wire logic ro_event_start,
  input wire logic [SLOT_W-1:0] ro_part,
  // Results
  output logic ro_truncate,
  output logic [NS-1:0] part_disable_ff,
  output logic readout_max_ff
);
  logic [SW:0] count_ff;
  logic [SW:0] nxt_count;
  logic trunc_ff;
  logic over;

  assign nxt_count = ro_event_start ? {{SW{1'b0}}, 1'b1} :
                     count_ff + {{SW{1'b0}}, 1'b1};
  // The limit is compared with the count including this word, so no word slips past the limit
  assign over = ro_valid && !trunc_ff && (nxt_count > {1'b0, max_size});
  // A new event's start word is never cut by the previous event's limit
  assign ro_truncate = (trunc_ff && !(ro_valid && ro_event_start)) ||
                       over;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
    end else if (ro_valid) begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trunc_ff <= 1'b0;
    end else if (ro_valid && ro_event_start && !over) begin
      trunc_ff <= 1'b0;
    end else if (over) begin
      trunc_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      part_disable_ff <= '0;
      readout_max_ff <= 1'b0;
    end else begin
      part_disable_ff <= '0;
      readout_max_ff <= over;
      if (over && ro_part < SLOT_W'(NS)) begin
        part_disable_ff[ro_part] <= 1'b1;
      end
    end
  end

  trunc_flags_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    over |=> readout_max_ff && $onehot(part_disable_ff))
    else $error("overflow did not disable partition");
  trunc_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    over |=> ro_truncate || (ro_valid && ro_event_start))
    else $error("truncation did not persist");
endmodule : rltc_evsize

/* core/rltc_pkg.sv */
// Purpose: Shared constants and types for the read-out link test control.
// Assumes: Word-indexed host register port, one clock domain.
// Notes: Register addresses are word indices on the host port.
// Contract
// - Test mode bit disables the real link; host test words replace it.
// - In test mode a rising bit 0 injects one test data/status word.
// - Bit 2 hands the second buffer memory port to the host.
// - First buffer memory port always serves the input link writes.
// - Zero suppress drops empty-source headers/trailers; header keeps a flag.
// - Bits 4-6 drive TCK/TDI/TMS; bit 7 reads TDO, writes ignored.
// - Bit 8 reads live link-down line, mirrored to link status output.
// - Bit 9 selects odd (0) or even (1) parity over 32 bits.
// - Rising bit 10 resets the input link; level has no effect.
// - Bit 11 freezes the pipeline; comes up set after reset.
// - Bits 15-12 are LED bits; only lower two drive pins.
// - After reset: no test mode, internal read access, freeze on.
// - Test data register holds a full 32-bit link word.
// - Test status bit 0 is control-word flag, bit 1 data-error flag.
// - Oversized event truncates, disables its partition, raises max condition.
// - Maximum event size resets to 0x400.
// - One word past the limit may slip out before truncation; here the first word past the limit is already cut.
// - 12-bit expected id increments per event complete over enabled sources.
// - Host may write a future id; late reported until trailers reach it.
// - 18-bit source mask; disabled sources are not awaited for completion.
package rltc_pkg;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] A_CTRL = 6'h1B;
  localparam logic [ADDR_W-1:0] A_TDATA = 6'h1C;
  localparam logic [ADDR_W-1:0] A_TSTAT = 6'h1D;
  localparam logic [ADDR_W-1:0] A_MAXSZ = 6'h1E;
  localparam logic [ADDR_W-1:0] A_EXPID = 6'h1F;
  localparam logic [ADDR_W-1:0] A_MASK = 6'h20;
  localparam int CTRL_W = 16;
  localparam int B_INJ = 0;
  localparam int B_TEST = 1;
  localparam int B_BMHOST = 2;
  localparam int B_ZS = 3;
  localparam int B_TCK = 4;
  localparam int B_TDI = 5;
  localparam int B_TMS = 6;
  localparam int B_TDO = 7;
  localparam int B_LDN = 8;
  localparam int B_PEVEN = 9;
  localparam int B_LRST = 10;
  localparam int B_FRZ = 11;
  localparam int B_LED0 = 12;
  localparam int B_LED1 = 13;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0800;
  localparam int TS_CTRL = 0;
  localparam int TS_DERR = 1;
  localparam int TSTAT_W = 2;
  localparam int DATA_W = 32;
  localparam int SZ_W = 12;
  localparam logic [SZ_W-1:0] MAXSZ_RST = 12'h400;
  localparam int EVID_W = 12;
  localparam int NSRC = 18;
  localparam int SLOT_W = 5;
  localparam int PARITY_BIT = 26;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic ctrl_n;
    logic derr_n;
  } rltc_link_word_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rltc_host_req_t;
endpackage : rltc_pkg

/* verification/rltc_host_model.sv */
// Purpose: Host processor model on the channel register port.
// Assumes: One word per request, launched just after a rising edge.
// Notes: Released address and data show inverted values, not the last ones.
`timescale 1ns/1ps
module rltc_host_model import rltc_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Register port
  output rltc_host_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  initial begin
    reg_req = '0;
  end
  // Callers never pass zero as the maximum size
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: '1};
    #1;
    while (reg_rvalid_ff !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    // A missing answer reads as unknown so the compare trips
    d = (reg_rvalid_ff === 1'b1) ? reg_rdata_ff : 'x;
  endtask : rd
  // One word per pass; the caller writes zero to leave test mode
  task automatic inject(input logic [31:0] d, input logic [1:0] s,
                        input logic ev);
    wr(A_CTRL, {22'h0, ev, 9'h002});
    wr(A_TDATA, d);
    wr(A_TSTAT, {30'h0, s});
    wr(A_CTRL, {22'h0, ev, 9'h003});
    wr(A_CTRL, {22'h0, ev, 9'h002});
  endtask : inject
endmodule : rltc_host_model

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the channel test and control registers.
// Assumes: Host model on the register port, bench drives all other inputs.
// Notes: Pulses are counted by monitors, so checks follow a settling delay.
`timescale 1ns/1ps
module tb_top import rltc_pkg::*; ;
  logic clk_sys = 1'b0, arst_n = 1'b0;
  rltc_host_req_t reg_req;
  logic [DATA_W-1:0] rdata;
  logic rvalid, link_in_valid = 0, link_down_n = 1, lfifo_not_empty = 1;
  rltc_link_word_t link_in = '0, il_word, last_w;
  logic il_valid, perr, lrst, ldn_st, lpop, frz, bm1, bm2, tck, tdi, tms;
  logic jtag_tdo = 0, ro_valid = 0, ro_st = 0, ro_end = 0, ro_hdr = 0;
  logic ro_trl = 0, ro_emp = 0, ro_drop, ro_trunc, rmax, late, early, evc;
  logic [4:0] ro_part = '0, trl_slot = '0;
  logic [1:0] led;
  logic [NSRC-1:0] zs, pdis, pd_acc = '0;
  logic trl_valid = 0;
  logic [EVID_W-1:0] trl_evid = '0, expid;
  logic [31:0] d;
  int error_cnt = 0, checked = 0, cyc = 0;
  int n_il = 0, n_pe = 0, n_lr = 0, n_rm = 0, n_late = 0, n_ec = 0;
  int n_ea = 0;
  always #5 clk_sys = ~clk_sys;
  rltc_ctrl rltc_ctrl_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid),
    .link_in(link_in), .link_in_valid(link_in_valid),
    .link_down_n(link_down_n), .il_word_ff(il_word), .il_valid_ff(il_valid),
    .parity_err_ff(perr), .link_reset_ff(lrst), .link_down_status_n(ldn_st),
    .lfifo_not_empty(lfifo_not_empty), .lfifo_pop(lpop), .pipe_freeze(frz),
    .bm_port1_link(bm1), .bm_port2_host(bm2), .jtag_tck(tck),
    .jtag_tdi(tdi), .jtag_tms(tms), .jtag_tdo(jtag_tdo), .led(led),
    .ro_valid(ro_valid), .ro_event_start(ro_st), .ro_event_end(ro_end),
    .ro_part(ro_part), .ro_is_hdr(ro_hdr), .ro_is_trl(ro_trl),
    .ro_src_empty(ro_emp), .ro_drop(ro_drop), .ro_truncate(ro_trunc),
    .zs_flags_ff(zs), .part_disable_ff(pdis), .readout_max_ff(rmax),
    .trl_valid(trl_valid), .trl_slot(trl_slot), .trl_evid(trl_evid),
    .evid_late_ff(late), .evid_early_ff(early), .event_complete_ff(evc),
    .expid_ff(expid));
  rltc_host_model rltc_host_model_i (.clk_sys(clk_sys), .reg_req(reg_req),
    .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid));
  always @(posedge clk_sys) begin
    if (il_valid === 1'b1) begin
      n_il++;
      last_w = il_word;
    end
    if (perr === 1'b1) n_pe++;
    if (lrst === 1'b1) n_lr++;
    if (rmax === 1'b1) n_rm++;
    if (late === 1'b1) n_late++;
    if (evc === 1'b1) n_ec++;
    if (early === 1'b1) n_ea++;
    pd_acc |= pdis;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic ro(input logic s, h, z, input logic [4:0] p);
    @(posedge clk_sys);
    {ro_valid, ro_st, ro_hdr, ro_emp, ro_part} <= {1'b1, s, h, z, p};
    #1;
  endtask : ro
  task automatic trl(input logic [4:0] s, input logic [11:0] e);
    @(posedge clk_sys);
    {trl_valid, trl_slot, trl_evid} <= {1'b1, s, e};
    @(posedge clk_sys);
    trl_valid <= 1'b0;
  endtask : trl
  task automatic t_reset();
    rltc_host_model_i.rd(A_CTRL, d);
    chk(d, 32'h0000_0900);
    rltc_host_model_i.rd(A_MAXSZ, d);
    chk(d, 32'h0000_0400);
    rltc_host_model_i.rd(6'h3F, d);
    chk(d, 32'h0);
    chk({frz, bm2, bm1, lpop}, 32'hA);
  endtask : t_reset
  task automatic t_ctrl();
    rltc_host_model_i.wr(A_CTRL, 32'h0000_F0F4);
    rltc_host_model_i.rd(A_CTRL, d);
    chk(d, 32'h0000_F174);
    chk({tms, tdi, tck, led, bm2, frz, lpop}, 32'hFD);
    jtag_tdo <= 1'b1;
    link_down_n <= 1'b0;
    wt(6);
    rltc_host_model_i.rd(A_CTRL, d);
    chk(d, 32'h0000_F0F4);
    chk(ldn_st, 32'h0);
    jtag_tdo <= 1'b0;
    link_down_n <= 1'b1;
    wt(6);
  endtask : t_ctrl
  task automatic t_inject();
    int i0, p0;
    i0 = n_il;
    p0 = n_pe;
    rltc_host_model_i.inject(32'h0000_0001, 2'b01, 1'b0);
    wt(4);
    chk(n_il - i0, 32'h1);
    chk(last_w.data, 32'h0000_0001);
    chk({last_w.ctrl_n, last_w.derr_n}, 32'h2);
    chk(n_pe - p0, 32'h0);
    rltc_host_model_i.wr(A_CTRL, 32'h3);
    rltc_host_model_i.wr(A_CTRL, 32'h3);
    @(posedge clk_sys);
    link_in_valid <= 1'b1;
    @(posedge clk_sys);
    link_in_valid <= 1'b0;
    wt(4);
    chk(n_il - i0, 32'h2);
    rltc_host_model_i.inject(32'h0, 2'b10, 1'b0);
    rltc_host_model_i.inject(32'h0000_0001, 2'b00, 1'b1);
    wt(4);
    chk(n_pe - p0, 32'h2);
    rltc_host_model_i.wr(A_CTRL, 32'h0);
    @(posedge clk_sys);
    link_in <= '{data: 32'h0000_0003, ctrl_n: 1'b1, derr_n: 1'b1};
    link_in_valid <= 1'b1;
    @(posedge clk_sys);
    link_in_valid <= 1'b0;
    wt(4);
    chk(n_il - i0, 32'h5);
    chk(last_w.data, 32'h0000_0003);
    chk(n_pe - p0, 32'h3);
  endtask : t_inject
  task automatic t_lreset();
    rltc_host_model_i.wr(A_CTRL, 32'h400);
    rltc_host_model_i.wr(A_CTRL, 32'h400);
    wt(3);
    chk(n_lr, 32'h1);
    rltc_host_model_i.wr(A_CTRL, 32'h0);
    rltc_host_model_i.wr(A_CTRL, 32'h400);
    wt(3);
    chk(n_lr, 32'h2);
    rltc_host_model_i.wr(A_CTRL, 32'h0);
  endtask : t_lreset
  task automatic t_maxsz();
    rltc_host_model_i.wr(A_MAXSZ, 32'h2);
    rltc_host_model_i.rd(A_MAXSZ, d);
    chk(d, 32'h2);
    ro(1'b1, 1'b0, 1'b0, 5'd3);
    chk(ro_trunc, 32'h0);
    ro(1'b0, 1'b0, 1'b0, 5'd3);
    chk(ro_trunc, 32'h0);
    ro(1'b0, 1'b0, 1'b0, 5'd3);
    chk(ro_trunc, 32'h1);
    @(posedge clk_sys);
    ro_valid <= 1'b0;
    wt(2);
    chk(n_rm, 32'h1);
    chk(pd_acc, 32'h8);
  endtask : t_maxsz
  task automatic t_zs();
    ro(1'b1, 1'b1, 1'b1, 5'd5);
    chk(ro_drop, 32'h0);
    @(posedge clk_sys);
    ro_valid <= 1'b0;
    rltc_host_model_i.wr(A_CTRL, 32'h8);
    ro(1'b1, 1'b1, 1'b1, 5'd5);
    chk(ro_drop, 32'h1);
    @(posedge clk_sys);
    ro_valid <= 1'b0;
    #1;
    chk(zs[5], 32'h1);
    @(posedge clk_sys);
    {ro_valid, ro_end, ro_emp} <= 3'b110;
    @(posedge clk_sys);
    {ro_valid, ro_end} <= 2'b00;
    #1;
    chk(zs[5], 32'h0);
    rltc_host_model_i.wr(A_CTRL, 32'h0);
  endtask : t_zs
  task automatic t_evid();
    rltc_host_model_i.wr(A_MASK, 32'h3);
    rltc_host_model_i.wr(A_EXPID, 32'h5);
    trl(5'd0, 12'h005);
    trl(5'd1, 12'h005);
    wt(2);
    chk(n_ec, 32'h1);
    rltc_host_model_i.rd(A_EXPID, d);
    chk(d, 32'h6);
    trl(5'd0, 12'h004);
    rltc_host_model_i.wr(A_EXPID, 32'hA);
    trl(5'd0, 12'h00C);
    trl(5'd0, 12'h006);
    wt(2);
    chk(n_late, 32'h2);
    chk(n_ea, 32'h1);
    trl(5'd0, 12'h00A);
    trl(5'd1, 12'h00A);
    wt(2);
    chk(n_ec, 32'h2);
    chk(expid, 32'hB);
  endtask : t_evid
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    wt(2);
    t_reset();
    t_ctrl();
    t_inject();
    t_lreset();
    t_maxsz();
    t_zs();
    t_evid();
    print_verdict();
  end
endmodule : tb_top
